// file: core/trm_pkg.sv
// package: constants, types and the configuration decode function for the transponder read-out modulator
// assumes a 125 MHz system clock and a sampled field clock of 100..150 kHz
package trm_pkg;
  localparam int POR_FC = 192;
  localparam int DELAY_FC = 8190;
  localparam logic [13:0] POR_LAST = 14'(POR_FC - 1);
  localparam logic [13:0] DELAY_LAST = 14'(DELAY_FC - 1);
  localparam logic [5:0] BLK_BITS = 6'h20;
  localparam logic [2:0] ST_LEN = 3'h4;
  localparam logic [3:0] P0_BLOCKS = 4'h8;
  localparam logic [2:0] PWD_BLOCK = 3'h7;
  localparam logic [2:0] TRACE_LIMIT = 3'h2;
  localparam logic [31:0] CFG_DELIVERY = 32'h0014_8000;
  // configuration word: bit n of the block sits at word bit 32-n
  localparam int RATE_LSB = 18;
  localparam int XMODE_POS = 17;
  localparam int MOD_LSB = 12;
  localparam int PSKCF_LSB = 10;
  localparam int LIMIT_LSB = 5;
  localparam int PWD_POS = 4;
  localparam int ST_POS = 3;
  localparam int PORDLY_POS = 0;
  // register byte addresses and command bits
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_PWD = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_MSEL = 8'h0C;
  localparam logic [7:0] ADR_MDATA = 8'h10;
  localparam int CMD_RST = 0;
  localparam int CMD_PAGE_RD = 1;
  localparam int CMD_DIRECT = 2;
  localparam int CMD_PAGE = 3;
  localparam int CMD_ADR_LSB = 4;
  localparam int MSEL_LOCK = 8;
  typedef enum logic [4:0] {
    mod_nrz = 5'h00, phase_shift_on_change = 5'h01, phase_shift_on_high = 5'h02,
    phase_shift_on_rise = 5'h03, freq_shift_5_8 = 5'h04, freq_shift_10_8 = 5'h05,
    freq_shift_8_5 = 5'h06, freq_shift_8_10 = 5'h07, mod_manchester = 5'h08, mod_biphase = 5'h10
  } trm_mod_e;
  typedef enum logic [1:0] {st_config = 2'h0, st_delay = 2'h1, st_regular = 2'h2, st_block = 2'h3} trm_state_e;
  typedef struct packed {
    logic [2:0] rate;
    trm_mod_e modsel;
    logic [1:0] psk_cf;
    logic [2:0] last_block_limit;
    logic password_protect_enable;
    logic seq_terminator_enable;
    logic ext_mode;
    logic por_delay;
  } trm_cfg_s;
  typedef struct packed {
    logic val;
    logic hole;
  } trm_sym_s;
  function automatic trm_cfg_s cfg_decode(input logic [31:0] w);
    trm_cfg_s c;
    c.rate = w[RATE_LSB +: 3];
    c.modsel = trm_mod_e'(w[MOD_LSB +: 5]);
    c.psk_cf = w[PSKCF_LSB +: 2];
    c.last_block_limit = w[LIMIT_LSB +: 3];
    c.password_protect_enable = w[PWD_POS];
    c.seq_terminator_enable = w[ST_POS];
    c.ext_mode = w[XMODE_POS];
    c.por_delay = w[PORDLY_POS];
    return c;
  endfunction
endpackage

// file: core/trm_sync.sv
// two-stage synchroniser for levels arriving from outside the system clock
// assumes nothing of the source beyond it being a level
`timescale 1ns/1ps
module trm_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_dout;

  // first stage feeds only the second one
  always_comb
  begin
    nxt_meta = din;
    nxt_dout = meta_ff;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_ff <= '0;
      dout <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      dout <= nxt_dout;
    end
  end
endmodule

// file: core/trm_encoder.sv
// data encoder: bit timing in field clocks and all line codings of the modulator
// assumes fc_tick pulses once per field clock and sym_in is valid whenever run is high
`timescale 1ns/1ps
module trm_encoder (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic fc_tick,
  input wire logic run,
  input trm_pkg::trm_cfg_s cfg,
  input trm_pkg::trm_sym_s sym_in,
  output logic take,
  output logic mod_out
);
  import trm_pkg::*;
  logic [7:0] cnt_ff, nxt_cnt, rate, half;
  logic [3:0] sc_ff, nxt_sc, sdiv;
  trm_sym_s cur_ff, nxt_cur;
  logic live_ff, nxt_live, ph_ff, nxt_ph, lvl_ff, nxt_lvl, nxt_take, nxt_mod, bound, coded;

  function automatic logic [7:0] rate_fc(input logic [2:0] code);
    case (code)
      3'h0: rate_fc = 8'h08;
      3'h1: rate_fc = 8'h10;
      3'h2: rate_fc = 8'h20;
      3'h3: rate_fc = 8'h28;
      3'h4: rate_fc = 8'h32;
      3'h5: rate_fc = 8'h40;
      3'h6: rate_fc = 8'h64;
      default: rate_fc = 8'h80;
    endcase
  endfunction

  // sub-carrier period in field clocks for the bit being sent
  function automatic logic [3:0] sub_div(input trm_mod_e m, input logic v, input logic [1:0] cf);
    case (m)
      freq_shift_8_5: sub_div = v ? 4'h5 : 4'h8;
      freq_shift_8_10: sub_div = v ? 4'hA : 4'h8;
      freq_shift_5_8: sub_div = v ? 4'h8 : 4'h5;
      freq_shift_10_8: sub_div = v ? 4'h8 : 4'hA;
      default: sub_div = (cf == 2'h0) ? 4'h2 : ((cf == 2'h1) ? 4'h4 : 4'h8);
    endcase
  endfunction

  // bit timing, phase and level tracking
  always_comb
  begin
    rate = rate_fc(cfg.rate);
    half = rate >> 1;
    sdiv = sub_div(cfg.modsel, cur_ff.val, cfg.psk_cf);
    bound = fc_tick && (!live_ff || cnt_ff == rate - 8'h01);
    nxt_cnt = cnt_ff;
    nxt_sc = sc_ff;
    nxt_cur = cur_ff;
    nxt_live = live_ff;
    nxt_ph = ph_ff;
    nxt_lvl = lvl_ff;
    nxt_take = run && bound;
    if (!run)
    begin
      nxt_cnt = '0;
      nxt_sc = '0;
      nxt_live = 1'b0;
      nxt_ph = 1'b0;
      nxt_lvl = 1'b0;
      nxt_cur = '0;
    end
    else if (bound)
    begin
      nxt_cnt = '0;
      nxt_sc = '0; // sub-carrier restarts aligned to the bit, hence the integer multiple need
      nxt_cur = sym_in;
      nxt_live = 1'b1;
      nxt_lvl = !lvl_ff;
      case (cfg.modsel)
        phase_shift_on_change: nxt_ph = ph_ff ^ (sym_in.val != cur_ff.val);
        phase_shift_on_high: nxt_ph = ph_ff ^ sym_in.val;
        phase_shift_on_rise: nxt_ph = ph_ff ^ (sym_in.val && !cur_ff.val);
        default: nxt_ph = ph_ff;
      endcase
    end
    else if (fc_tick)
    begin
      nxt_cnt = cnt_ff + 8'h01;
      nxt_sc = (sc_ff == sdiv - 4'h1) ? 4'h0 : sc_ff + 4'h1;
      if (cnt_ff == half - 8'h01 && cur_ff.val)
        nxt_lvl = !lvl_ff;
    end
  end

  // line coding of the current symbol
  always_comb
  begin
    case (cfg.modsel)
      mod_nrz: coded = cur_ff.val;
      mod_manchester: coded = (cnt_ff >= half) ? cur_ff.val : !cur_ff.val;
      mod_biphase: coded = lvl_ff;
      freq_shift_8_5, freq_shift_8_10, freq_shift_5_8, freq_shift_10_8: coded = sc_ff < (sdiv >> 1);
      phase_shift_on_change, phase_shift_on_high, phase_shift_on_rise:
        coded = (sc_ff < (sdiv >> 1)) ^ ph_ff;
      default: coded = 1'b0;
    endcase
    if (!live_ff)
      nxt_mod = 1'b0;
    else if (cur_ff.hole)
      nxt_mod = (cfg.modsel == mod_manchester);
    else
      nxt_mod = coded;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_ff <= '0;
      sc_ff <= '0;
      cur_ff <= '0;
      live_ff <= 1'b0;
      ph_ff <= 1'b0;
      lvl_ff <= 1'b0;
      take <= 1'b0;
      mod_out <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      sc_ff <= nxt_sc;
      cur_ff <= nxt_cur;
      live_ff <= nxt_live;
      ph_ff <= nxt_ph;
      lvl_ff <= nxt_lvl;
      take <= nxt_take;
      mod_out <= nxt_mod;
    end
  end
endmodule

// file: core/trm_readout.sv
// top of the transponder read-out: memory, start-up sequence, read sequencer, wishbone slave
// assumes a free or gapped field clock pin and a gap pin, both asynchronous to clk_sys
`timescale 1ns/1ps
module trm_readout #(
  parameter logic [7:0] ALLOC_CLASS = 8'hA5, // arbitrary value
  parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary value
  parameter logic [2:0] CHIP_REV = 3'h1,
  parameter logic [4:0] CUSTOMER_CODE = 5'h00,
  parameter logic [19:0] LOT_NUMBER = 20'h0_1234,
  parameter logic [4:0] WAFER_NUMBER = 5'h03,
  parameter logic [14:0] DIE_NUMBER = 15'h0042
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic field_clk,
  input wire logic field_gap,
  output logic damp_out
);
  import trm_pkg::*;
  // traceability: class, maker, chip reference, then 40-bit serial of lot, wafer and die number
  localparam logic [63:0] TRACE = {ALLOC_CLASS, MAKER_CODE, CHIP_REV, CUSTOMER_CODE,
                                   LOT_NUMBER, WAFER_NUMBER, DIE_NUMBER};

  logic [1:0] pins_s;
  logic fc_s, gap_s, fc_prev_ff, fc_tick, take, enc_mod;
  trm_state_e st_ff, nxt_st;
  logic [13:0] fc_cnt_ff, nxt_fc;
  trm_cfg_s mode_ff, nxt_mode, cfg0;
  logic page_ff, nxt_page, lead_ff, nxt_lead, run_ff, nxt_run, damp_ff, nxt_damp;
  logic [2:0] blk_ff, nxt_blk, stc_ff, nxt_stc, first_blk, lim_eff, start_blk;
  logic [5:0] bit_ff, nxt_bit;
  logic do_start, with_st, wrap;
  trm_sym_s sym;
  logic [31:0] src_word;
  logic [31:0] mem_ff [8];
  logic [31:0] nxt_mem [8];
  logic [7:0] lock_ff, nxt_lock;
  logic [3:0] msel_ff, nxt_msel;
  logic lockv_ff, nxt_lockv, ack_ff, nxt_ack;
  logic [31:0] pwd_ff, nxt_pwd, dat_ff, nxt_dat, rd_val, msel_word;
  logic acc, wr, cmd_rst, cmd_page_rd, cmd_direct;

  // merge a write into a word by byte lanes
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
      lane_merge[8*i +: 8] = sel[i] ? d[8*i +: 8] : old[8*i +: 8];
  endfunction

  // word behind a page and block; page 1 aliases block 0 and reads zero beyond traceability
  function automatic logic [31:0] block_word(input logic pg, input logic [2:0] b, input logic [31:0] c0,
                                              input logic [31:0] p0);
    if (!pg)
      block_word = p0;
    else if (b == 3'h0)
      block_word = c0;
    else if (b == 3'h1)
      block_word = TRACE[63:32];
    else if (b == 3'h2)
      block_word = TRACE[31:0];
    else
      block_word = '0;
  endfunction

  trm_sync #(.W(2)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .din({field_gap, field_clk}),
    .dout(pins_s)
  );

  trm_encoder u_enc (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .fc_tick(fc_tick),
    .run(run_ff),
    .cfg(mode_ff),
    .sym_in(sym),
    .take(take),
    .mod_out(enc_mod)
  );

  // field clock edge found on the synchronised level
  assign fc_s = pins_s[0];
  assign gap_s = pins_s[1];
  assign fc_tick = fc_s && !fc_prev_ff;

  // bus decode: ack one cycle after the strobe, commands act at that same edge
  assign acc = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr = acc && wb_we_i;
  assign cmd_rst = wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[CMD_RST];
  assign cmd_page_rd = wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[CMD_PAGE_RD];
  assign cmd_direct = wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[CMD_DIRECT];

  // symbol offered to the encoder: leading zero, terminator, then block data
  always_comb
  begin
    cfg0 = cfg_decode(mem_ff[0]);
    src_word = block_word(page_ff, blk_ff, mem_ff[0], mem_ff[blk_ff]);
    sym.val = src_word[5'(BLK_BITS - bit_ff)];
    sym.hole = 1'b0;
    if (lead_ff)
      sym.val = 1'b0;
    else if (stc_ff != 3'h0)
    begin
      sym.val = 1'b1;
      sym.hole = (stc_ff == 3'h3) || (stc_ff == 3'h1);
    end
  end

  // start-up and read sequencer
  always_comb
  begin
    nxt_st = st_ff;
    nxt_fc = fc_cnt_ff;
    nxt_mode = mode_ff;
    nxt_page = page_ff;
    nxt_blk = blk_ff;
    nxt_bit = bit_ff;
    nxt_lead = lead_ff;
    nxt_stc = stc_ff;
    nxt_run = (st_ff == st_regular) || (st_ff == st_block);
    lim_eff = page_ff ? TRACE_LIMIT : mode_ff.last_block_limit;
    first_blk = (st_ff == st_block) ? blk_ff : ((!page_ff && lim_eff == 3'h0) ? 3'h0 : 3'h1);
    wrap = (st_ff == st_block) || lim_eff <= 3'h1 || blk_ff == lim_eff;
    do_start = 1'b0;
    with_st = 1'b0;
    start_blk = first_blk;
    unique case (st_ff)
      st_config:
      begin
        if (gap_s)
          nxt_fc = '0;
        else if (fc_tick)
        begin
          nxt_fc = fc_cnt_ff + 14'h0001;
          if (fc_cnt_ff == POR_LAST)
          begin
            nxt_fc = '0;
            nxt_mode = cfg0;
            nxt_page = 1'b0;
            nxt_lead = 1'b1;
            nxt_st = cfg0.por_delay ? st_delay : st_regular;
          end
        end
      end
      st_delay:
      begin
        if (gap_s)
        begin
          nxt_st = st_config;
          nxt_fc = '0;
        end
        else if (fc_tick)
        begin
          nxt_fc = fc_cnt_ff + 14'h0001;
          if (fc_cnt_ff == DELAY_LAST)
          begin
            nxt_fc = '0;
            nxt_st = st_regular;
          end
        end
      end
      st_regular, st_block:
      begin
        if (cmd_rst)
        begin
          nxt_st = st_config;
          nxt_fc = '0;
          nxt_run = 1'b0;
        end
        else if (cmd_page_rd || cmd_direct)
        begin
          nxt_run = 1'b0; // restart the encoder so the leading zero is a whole bit
          nxt_lead = 1'b1;
          nxt_stc = '0;
          nxt_st = st_regular;
          if (!cmd_direct)
            nxt_page = wb_dat_i[CMD_PAGE];
          else if (mode_ff.password_protect_enable && pwd_ff != mem_ff[PWD_BLOCK])
            nxt_st = st_regular;
          else
          begin
            nxt_st = st_block;
            nxt_page = wb_dat_i[CMD_PAGE];
            nxt_blk = wb_dat_i[CMD_ADR_LSB +: 3];
          end
        end
        else if (take && run_ff) // a take left over from before a restart would eat the leading zero
        begin
          if (lead_ff)
          begin
            nxt_lead = 1'b0;
            do_start = 1'b1;
            with_st = 1'b1;
          end
          else if (stc_ff != 3'h0)
            nxt_stc = stc_ff - 3'h1;
          else if (bit_ff == BLK_BITS)
          begin
            do_start = 1'b1;
            with_st = wrap;
            start_blk = wrap ? first_blk : blk_ff + 3'h1;
          end
          else
            nxt_bit = bit_ff + 6'h01;
        end
      end
    endcase
    if (do_start)
    begin
      nxt_blk = start_blk;
      nxt_bit = 6'h01;
      nxt_mode = cfg0;
      nxt_stc = (with_st && cfg0.seq_terminator_enable && !cfg0.ext_mode) ? ST_LEN : 3'h0;
    end
    nxt_damp = (st_ff == st_config || st_ff == st_delay) ? 1'b1 : enc_mod;
  end

  // register file and memory programming
  always_comb
  begin
    nxt_mem = mem_ff;
    nxt_lock = lock_ff;
    nxt_msel = msel_ff;
    nxt_lockv = lockv_ff;
    nxt_pwd = pwd_ff;
    nxt_ack = acc;
    nxt_dat = '0;
    msel_word = (msel_ff >= P0_BLOCKS) ? block_word(1'b1, 3'(msel_ff - P0_BLOCKS + 4'h1), mem_ff[0], mem_ff[0])
                                      : mem_ff[msel_ff[2:0]];
    unique case (wb_adr_i)
      ADR_CMD: rd_val = {24'h00_0000, 1'b0, blk_ff, page_ff, 3'h0};
      ADR_PWD: rd_val = pwd_ff;
      ADR_STAT: rd_val = {15'h0000, damp_ff, lead_ff, stc_ff, bit_ff, blk_ff, page_ff, st_ff};
      ADR_MSEL: rd_val = {22'h00_0000, (msel_ff < P0_BLOCKS) ? lock_ff[msel_ff[2:0]] : 1'b1,
                          lockv_ff, 4'h0, msel_ff};
      ADR_MDATA: rd_val = msel_word;
      default: rd_val = '0;
    endcase
    if (acc && !wb_we_i)
      nxt_dat = rd_val;
    if (wr && wb_adr_i == ADR_PWD)
      nxt_pwd = lane_merge(pwd_ff, wb_dat_i, wb_sel_i);
    if (wr && wb_adr_i == ADR_MSEL && wb_sel_i[0])
      nxt_msel = wb_dat_i[3:0];
    if (wr && wb_adr_i == ADR_MSEL && wb_sel_i[1])
      nxt_lockv = wb_dat_i[MSEL_LOCK];
    if (wr && wb_adr_i == ADR_MDATA && msel_ff < P0_BLOCKS && !lock_ff[msel_ff[2:0]])
    begin
      nxt_mem[msel_ff[2:0]] = lane_merge(mem_ff[msel_ff[2:0]], wb_dat_i, wb_sel_i);
      nxt_lock[msel_ff[2:0]] = lockv_ff;
    end
  end

  // all state registers; the memory resets to the delivery configuration
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      fc_prev_ff <= 1'b0;
      st_ff <= st_config;
      fc_cnt_ff <= '0;
      mode_ff <= '0;
      page_ff <= 1'b0;
      blk_ff <= '0;
      bit_ff <= 6'h01;
      lead_ff <= 1'b0;
      stc_ff <= '0;
      run_ff <= 1'b0;
      damp_ff <= 1'b0;
      mem_ff <= '{CFG_DELIVERY, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      lock_ff <= '0;
      msel_ff <= '0;
      lockv_ff <= 1'b0;
      pwd_ff <= '0;
      ack_ff <= 1'b0;
      dat_ff <= '0;
    end
    else
    begin
      fc_prev_ff <= fc_s;
      st_ff <= nxt_st;
      fc_cnt_ff <= nxt_fc;
      mode_ff <= nxt_mode;
      page_ff <= nxt_page;
      blk_ff <= nxt_blk;
      bit_ff <= nxt_bit;
      lead_ff <= nxt_lead;
      stc_ff <= nxt_stc;
      run_ff <= nxt_run;
      damp_ff <= nxt_damp;
      mem_ff <= nxt_mem;
      lock_ff <= nxt_lock;
      msel_ff <= nxt_msel;
      lockv_ff <= nxt_lockv;
      pwd_ff <= nxt_pwd;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign damp_out = damp_ff;

  // checks on the sequencer and memory
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_init_damped: assert property ((st_ff == st_config || st_ff == st_delay) |=> damp_ff)
    else $error("load not damped during initialisation");
  a_gap_restart: assert property (gap_s && st_ff != st_regular && st_ff != st_block
    |=> st_ff == st_config && fc_cnt_ff == 14'h0000)
    else $error("gap did not restart initialisation");
  a_config_end: assert property (st_ff == st_config && !gap_s && fc_tick && fc_cnt_ff == POR_LAST
    |=> lead_ff && st_ff == ($past(cfg0.por_delay) ? st_delay : st_regular))
    else $error("configuration period ended wrongly");
  a_delay_end: assert property (st_ff == st_delay && !gap_s && fc_tick && fc_cnt_ff == DELAY_LAST
    |=> st_ff == st_regular && lead_ff)
    else $error("start-up delay did not end in regular read");
  a_first_zero: assert property (take && run_ff && lead_ff && (st_ff == st_regular || st_ff == st_block)
    |-> !u_enc.cur_ff.val)
    else $error("first offered bit is not zero");
  a_cfg_repeat: assert property (take && st_ff == st_regular && !page_ff && !lead_ff && stc_ff == 3'h0
    && bit_ff == BLK_BITS && mode_ff.last_block_limit == 3'h0 |=> blk_ff == 3'h0 && bit_ff == 6'h01)
    else $error("limit zero did not repeat the configuration block");
  a_block_repeat: assert property (take && st_ff == st_block && !cmd_rst && !cmd_direct && !cmd_page_rd
    && !lead_ff && stc_ff == 3'h0 && bit_ff == BLK_BITS |=> blk_ff == $past(blk_ff) ##1 st_ff == st_block)
    else $error("block read left the addressed block");
  a_pwd_fail: assert property (cmd_direct && !cmd_rst && mode_ff.password_protect_enable
    && pwd_ff != mem_ff[PWD_BLOCK] && (st_ff == st_regular || st_ff == st_block) |=> st_ff == st_regular)
    else $error("password mismatch did not return to regular read");
  a_zero_blocks: assert property (st_ff == st_block && page_ff && blk_ff >= 3'h3 && !lead_ff
    && stc_ff == 3'h0 |-> !sym.val)
    else $error("empty page 1 block sent a one");
  a_term_gate: assert property (stc_ff != 3'h0 |-> mode_ff.seq_terminator_enable && !mode_ff.ext_mode)
    else $error("terminator sent while disabled");
  a_lock_hold: assert property (wr && wb_adr_i == ADR_MDATA && msel_ff < P0_BLOCKS && lock_ff[msel_ff[2:0]]
    |=> mem_ff[$past(msel_ff[2:0])] == $past(mem_ff[msel_ff[2:0]]) && lock_ff == $past(lock_ff))
    else $error("locked block was reprogrammed");
  c_block_read: cover property (st_ff == st_block && take && bit_ff == BLK_BITS);
  c_terminator: cover property (stc_ff == ST_LEN ##[1:300] stc_ff == 3'h1);
  c_delay_done: cover property (st_ff == st_delay ##1 st_ff == st_regular);
  c_page1_read: cover property (st_ff == st_regular && page_ff && blk_ff == 3'h2);
endmodule

// file: verif/trm_reader_model.sv
// reader model: field clock and field gaps
// assumes the bench raises gap_req to open a gap
`timescale 1ns/1ps
module trm_reader_model (
  input wire logic gap_req,
  output logic field_clk,
  output logic field_gap
);
  // no field during a gap, so its clock stands still low
  initial field_clk = 1'b0;
  always #40 field_clk = gap_req ? 1'b0 : ~field_clk;
  assign field_gap = gap_req;
endmodule

// file: verif/trm_readout_test.sv
// bench: wishbone tests of the read-out block
// assumes the reader model gives the field clock
`timescale 1ns/1ps
module trm_readout_test;
  import trm_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic gap = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, field_clk, field_gap, damp_out;
  int fail_count = 0;
  int n_checks = 0;
  // test configuration: rf/8, nrz, limit 0, terminator on (block bit 29)
  localparam logic [31:0] CFG_TEST = 32'h0000_0008;
  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;
  trm_readout trm_readout_inst (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .field_clk(field_clk), .field_gap(field_gap), .damp_out(damp_out));
  trm_reader_model trm_reader_model_inst (.gap_req(gap), .field_clk(field_clk), .field_gap(field_gap));
  // verdict in one place; also the exit of the bus, state-poll and frame-start timeouts
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // classic cycle: hold until ack, take data there, then idle a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    q = wb_dat_o;
    cyc <= 1'b0;
    @(posedge clk_sys);
    if (n == 20)
    begin
      fail_count++;
      final_report();
    end
  endtask
  // poll the state field, bounded
  task automatic wait_state(input logic [1:0] s);
    int i;
    for (i = 0; i < 900; i++)
    begin
      bus(1'b0, ADR_STAT, 32'h0);
      if (q[1:0] === s)
        break;
    end
    chk("state", {30'h0, q[1:0]}, {30'h0, s});
    if (i == 900)
      final_report();
  endtask
  // nrz stream, 80 cycles a bit: terminator 1010, configuration block bits 1..32, first three bits 101 of the next terminator
  task automatic frame_check();
    int k;
    logic e;
    for (k = 0; k < 900 && damp_out !== 1'b0; k++)
      @(posedge clk_sys);
    for (k = 0; k < 900 && damp_out !== 1'b1; k++)
      @(posedge clk_sys);
    chk("frame start", {31'h0, damp_out}, 32'h1);
    if (damp_out !== 1'b1)
      final_report();
    repeat (40) @(posedge clk_sys);
    for (k = 0; k < 39; k++)
    begin
      e = (k < 4 || k > 35) ? !k[0] : CFG_TEST[35 - k];
      chk("nrz bit", {31'h0, damp_out}, {31'h0, e});
      repeat (80) @(posedge clk_sys);
    end
  endtask
  // test sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("damp", {31'h0, damp_out}, 32'h1);
    repeat (1000) @(posedge clk_sys);
    gap <= 1'b1;
    repeat (100) @(posedge clk_sys);
    gap <= 1'b0;
    repeat (1000) @(posedge clk_sys);
    chk("damp", {31'h0, damp_out}, 32'h1);
    bus(1'b0, ADR_STAT, 32'h0);
    chk("restart", {30'h0, q[1:0]}, 32'h0);
    wait_state(2'h2);
    $display("init test done");
    bus(1'b1, ADR_MSEL, 32'h1);
    bus(1'b1, ADR_MDATA, 32'h1234ABCD);
    bus(1'b0, ADR_MDATA, 32'h0);
    chk("blk1", q, 32'h1234ABCD);
    bus(1'b1, ADR_MSEL, 32'h101);
    bus(1'b1, ADR_MDATA, 32'h5555AAAA);
    bus(1'b1, ADR_MDATA, 32'h0);
    bus(1'b0, ADR_MDATA, 32'h0);
    chk("locked", q, 32'h5555AAAA);
    bus(1'b0, ADR_MSEL, 32'h0);
    chk("lock", {31'h0, q[9]}, 32'h1);
    bus(1'b1, ADR_MSEL, 32'h8);
    bus(1'b1, ADR_MDATA, 32'h0);
    bus(1'b0, ADR_MDATA, 32'h0);
    chk("trace1", q, {8'hA5, 8'h3C, 3'h1, 5'h00, 8'h01});
    bus(1'b1, ADR_MSEL, 32'h9);
    bus(1'b0, ADR_MDATA, 32'h0);
    chk("trace2", q, {12'h234, 5'h03, 15'h0042});
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("memory test done");
    bus(1'b1, ADR_MSEL, 32'h0);
    bus(1'b1, ADR_MDATA, CFG_TEST);
    bus(1'b1, ADR_CMD, 32'h1);
    bus(1'b0, ADR_STAT, 32'h0);
    chk("reset cmd", {30'h0, q[1:0]}, 32'h0);
    wait_state(2'h2);
    frame_check();
    $display("stream test done");
    bus(1'b1, ADR_CMD, 32'h3C);
    wait_state(2'h3);
    bus(1'b0, ADR_CMD, 32'h0);
    chk("page blk", q, 32'h38);
    repeat (3200) @(posedge clk_sys);
    bus(1'b0, ADR_STAT, 32'h0);
    chk("block stays", {26'h0, q[5:0]}, 32'h1F);
    bus(1'b1, ADR_CMD, 32'h1);
    wait_state(2'h0);
    $display("command test done");
    final_report();
  end
endmodule
